// [core/mck_defs_ram.sv]
/*
 Shared constants and types for the error dispatch block, plus the small
 logout area memory that holds the logout frames built on error entry.
 Assumes one clock, hclk, and that the main block arbitrates the single
 memory port between its own frame builder and the register bus.
*/
`timescale 1ns/1ps

package mck_pkg;
   // Register byte offsets on the bus
   localparam logic [8:0] OFF_CTRL = 9'h000;
   localparam logic [8:0] OFF_VT_BASE = 9'h004;
   localparam logic [8:0] OFF_ERR_SUM = 9'h008;
   localparam logic [8:0] OFF_CPU_OFF = 9'h00C;
   localparam logic [8:0] OFF_PLAT_OFF = 9'h010;
   localparam logic [8:0] OFF_FRAME_SIZE = 9'h014;
   localparam logic [8:0] OFF_FRAME_BASE = 9'h018;
   localparam logic [8:0] OFF_LOC_LO = 9'h01C;
   localparam logic [8:0] OFF_LOC_HI = 9'h020;
   localparam logic [8:0] OFF_VA_LO = 9'h024;
   localparam logic [8:0] OFF_VA_HI = 9'h028;
   localparam logic [8:0] OFF_PARAM_LO = 9'h02C;
   localparam logic [8:0] OFF_PARAM_HI = 9'h030;
   localparam logic [8:0] OFF_STATUS = 9'h034;
   localparam logic [2:0] OFF_LOG_HI3 = 3'h4;    // addr[8:6] of the logout window 0x100..0x13C
   // Control fields
   localparam int CTRL_BUILD_BIT = 0;
   localparam int CTRL_SIZE_LSB = 1;
   localparam logic [2:0] CTRL_RST = 3'h1;      // Frames built, 512-entry table
   // Error summary fields
   localparam int MCHK_BUSY_BIT = 0;
   localparam int SYS_CORRECTABLE_BUSY_BIT = 1;
   localparam int PROC_CORRECTABLE_BUSY_BIT = 2;
   localparam int SYS_QUIET_BIT = 3;
   localparam int PROC_QUIET_BIT = 4;
   // Frame flag fields
   localparam int FLAG_RETRY_BIT = 31;
   localparam int FLAG_SECOND_BIT = 30;
   // Frame header reset values
   localparam logic [31:0] FRAME_SIZE_RST = 32'h0000_0040;
   localparam logic [31:0] CPU_OFF_RST = 32'h0000_0010;
   localparam logic [31:0] PLAT_OFF_RST = 32'h0000_0040;
   // Vector table geometry
   localparam int VT_PAGE_BITS = 13;
   localparam int VT_PFN_W = 32 - VT_PAGE_BITS;
   localparam int ENTRY_SHIFT = 4;
   localparam logic [11:0] ENTRIES_MIN = 12'h200;
   localparam logic [1:0] SIZE_CODE_MAX = 2'h2;
   localparam logic [31:0] PARAM_STEP = 32'h0000_0008;
   localparam logic [15:0] STATIC_LAST = 16'h1FF0;
   // Entry offsets used for error dispatch
   localparam logic [15:0] VEC_PROC_FATAL = 16'h0670;
   localparam logic [15:0] VEC_SYS_FATAL = 16'h0660;
   localparam logic [15:0] VEC_PROC_CORR = 16'h0630;
   localparam logic [15:0] VEC_SYS_CORR = 16'h0620;
   localparam logic [63:0] LOCATOR_NONE = 64'hFFFF_FFFF_FFFF_FFFF;
   // Logout area memory
   localparam int LOG_WORDS = 16;
   localparam int LOG_AW = 4;
   // Event indices, lowest index has the highest priority
   localparam int EV_N = 4;
   localparam logic [1:0] EV_PROC_FATAL = 2'h0;
   localparam logic [1:0] EV_SYS_FATAL = 2'h1;
   localparam logic [1:0] EV_PROC_CORR = 2'h2;
   localparam logic [1:0] EV_SYS_CORR = 2'h3;

   typedef enum logic [3:0] {
      CL_FAULT = 4'h0, CL_ARITH = 4'h1, CL_AST = 4'h2, CL_ALIGN = 4'h3, CL_SYNC = 4'h4,
      CL_SOFT = 4'h5, CL_HARD = 4'h6, CL_DEVICE = 4'h7, CL_MCHECK = 4'h8
   } vec_class_e;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_HDR0 = 9'h002, ST_HDR1 = 9'h004, ST_HDR2 = 9'h008,
      ST_HDR3 = 9'h010, ST_FIX = 9'h020, ST_FETCH_VA = 9'h040,
      ST_FETCH_PARAM = 9'h080, ST_ENTER = 9'h100
   } disp_state_e;

   // Sorts an entry offset into one of the nine entry classes
   function automatic vec_class_e classify(input logic [15:0] off);
      if (off == VEC_PROC_FATAL || off == VEC_SYS_FATAL ||
          off == VEC_PROC_CORR || off == VEC_SYS_CORR) return CL_MCHECK;
      else if (off < 16'h0200) return CL_FAULT;
      else if (off < 16'h0240) return CL_ARITH;
      else if (off < 16'h0280) return CL_AST;
      else if (off < 16'h0400) return CL_ALIGN;
      else if (off < 16'h0500) return CL_SYNC;
      else if (off < 16'h0600) return CL_SOFT;
      else if (off < 16'h0800) return CL_HARD;
      else return CL_DEVICE;
   endfunction : classify
endpackage : mck_pkg

module logout_ram import mck_pkg::*; (
   input wire logic hclk,
   input wire logic en,
   input wire logic we,
   input wire logic [LOG_AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem [LOG_WORDS];   // Frame storage, no reset needed

   // Single port, read data registered
   always_ff @(posedge hclk) begin
      if (en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end
endmodule : logout_ram

// [core/mcheck_dispatch.sv]
/*
 Error entry and dispatch: builds logout frames, locates the vector table
 entry for the error, fetches handler address and parameter, and reports
 the frame location. Registers sit on an AHB-Lite slave port.
 Assumes the table fetch port returns one quadword per request with a
 single-cycle ack while the request is held, and that error inputs are
 synchronous single-cycle pulses.
*/
`timescale 1ns/1ps

module mcheck_dispatch import mck_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic err_proc_fatal,
   input wire logic err_sys_fatal,
   input wire logic err_proc_corr,
   input wire logic err_sys_corr,
   input wire logic retry_ok,
   output logic vt_req,
   output logic [31:0] vt_addr,
   input wire logic vt_ack,
   input wire logic [63:0] vt_rdata,
   output logic handler_start,
   output logic [63:0] handler_va,
   output logic [63:0] handler_param,
   output logic [63:0] frame_locator_register,
   output logic console_halt
);
   // Software-visible configuration
   logic [2:0] ctrl;                      // Build enable and table size code
   logic [VT_PFN_W-1:0] vector_table_base_reg;
   logic [4:0] error_summary_reg;         // Busy flags and report suppression
   logic [31:0] cpu_off;
   logic [31:0] platform_info_offset;
   logic [31:0] frame_size;
   logic [LOG_AW-1:0] frame_base;         // Frame word index in the logout area
   logic vec_fault;                       // Entry lay outside the table
   vec_class_e last_class;
   // Bus slave state
   logic bus_issue;
   logic bus_finish;
   logic bus_wr;
   logic [8:0] bus_addr;
   logic issue_go;
   logic bus_mem;
   // Dispatch state
   disp_state_e state;
   logic [EV_N-1:0] pend;
   logic [EV_N-1:0] ev_in;
   logic take_any;
   logic [1:0] take_idx;
   logic take_fatal;
   logic [2:0] take_busy_bit;
   logic take_busy;
   logic take_quiet;
   logic start_go;
   logic [2:0] sum_set;
   logic [15:0] cur_vec;
   logic [31:0] cur_flags;
   logic cur_corr;
   logic cur_built;
   logic [LOG_AW-1:0] cur_base;
   logic corr_live;                       // A correctable frame still sits in the area
   logic [31:0] corr_flags;
   logic [LOG_AW-1:0] corr_base;
   logic [15:0] next_vec;
   logic [31:0] vt_base_addr;
   logic [31:0] entry_addr;
   logic [11:0] table_entries;
   logic in_range;
   // Logout memory port
   logic hw_mem;
   logic mem_en;
   logic mem_we;
   logic [LOG_AW-1:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic [31:0] rd_word;

   assign ev_in = {err_sys_corr, err_proc_corr, err_sys_fatal, err_proc_fatal};

   // Bus side decode; the frame builder owns the memory port, so bus waits
   assign hw_mem = (state == ST_HDR0) || (state == ST_HDR1) || (state == ST_HDR2) ||
                   (state == ST_HDR3) || (state == ST_FIX);
   assign issue_go = bus_issue && !hw_mem;
   assign bus_mem = (bus_addr[8:6] == OFF_LOG_HI3);

   // Table geometry: base from page frame, size from control code
   assign vt_base_addr = {vector_table_base_reg, {VT_PAGE_BITS{1'b0}}};
   assign entry_addr = vt_base_addr + {16'h0000, cur_vec};
   assign table_entries = (ctrl[CTRL_SIZE_LSB +: 2] > SIZE_CODE_MAX) ?
                          (ENTRIES_MIN << SIZE_CODE_MAX) :
                          (ENTRIES_MIN << ctrl[CTRL_SIZE_LSB +: 2]);
   assign in_range = (cur_vec >> ENTRY_SHIFT) < {4'h0, table_entries};

   // Priority pick among pending events, fatal before correctable
   always_comb begin
      take_any = 1'b0;
      take_idx = 2'h0;
      for (int i = EV_N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            take_any = 1'b1;
            take_idx = 2'(i);
         end
      end
   end

   // Per-event busy flag, suppression and entry offset
   always_comb begin
      take_fatal = (take_idx == EV_PROC_FATAL) || (take_idx == EV_SYS_FATAL);
      take_busy_bit = 3'h0;
      take_quiet = 1'b0;
      next_vec = VEC_PROC_FATAL;
      case (take_idx)
         EV_PROC_FATAL: begin
            take_busy_bit[MCHK_BUSY_BIT] = 1'b1;
         end
         EV_SYS_FATAL: begin
            take_busy_bit[MCHK_BUSY_BIT] = 1'b1;
            next_vec = VEC_SYS_FATAL;
         end
         EV_PROC_CORR: begin
            take_busy_bit[PROC_CORRECTABLE_BUSY_BIT] = 1'b1;
            take_quiet = error_summary_reg[PROC_QUIET_BIT];
            next_vec = VEC_PROC_CORR;
         end
         default: begin
            take_busy_bit[SYS_CORRECTABLE_BUSY_BIT] = 1'b1;
            take_quiet = error_summary_reg[SYS_QUIET_BIT];
            next_vec = VEC_SYS_CORR;
         end
      endcase
      take_busy = |(take_busy_bit & error_summary_reg[2:0]);
      start_go = (state == ST_IDLE) && take_any && !take_busy && !take_quiet;
      sum_set = start_go ? take_busy_bit : 3'h0;
   end

   // Pending latches, one per error source; an arrival beats the take
   for (genvar g = 0; g < EV_N; g++) begin : g_pend
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pend[g] <= 1'b0;
         end else if (ev_in[g]) begin
            pend[g] <= 1'b1;
         end else if (state == ST_IDLE && take_any && take_idx == 2'(g)) begin
            pend[g] <= 1'b0;
         end
      end
   end

   // Memory port: frame header words take priority over bus accesses
   always_comb begin
      mem_en = hw_mem || (issue_go && bus_mem);
      mem_we = hw_mem || (issue_go && bus_mem && bus_wr);
      mem_addr = bus_addr[5:2];
      mem_wdata = hwdata;
      case (state)
         ST_HDR0: begin
            mem_addr = cur_base;
            mem_wdata = frame_size;
         end
         ST_HDR1: begin
            mem_addr = LOG_AW'(cur_base + 1'b1);
            mem_wdata = cur_flags;
         end
         ST_HDR2: begin
            mem_addr = LOG_AW'(cur_base + 2'h2);
            mem_wdata = cpu_off;
         end
         ST_HDR3: begin
            mem_addr = LOG_AW'(cur_base + 2'h3);
            mem_wdata = platform_info_offset;
         end
         ST_FIX: begin
            mem_addr = LOG_AW'(corr_base + 1'b1);
            mem_wdata = corr_flags | (32'h1 << FLAG_SECOND_BIT);
         end
         default: begin
         end
      endcase
   end

   logout_ram u_logout_ram (
      .hclk(hclk),
      .en(mem_en),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // Bus handshake: capture, issue (waits while frames are written), finish
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_issue <= 1'b0;
         bus_finish <= 1'b0;
         bus_wr <= 1'b0;
         bus_addr <= 9'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;   // Always OKAY, unmapped reads give zero
         if (hsel && hready && htrans[1]) begin
            bus_issue <= 1'b1;
            bus_wr <= hwrite;
            bus_addr <= haddr[8:0];
            hreadyout <= 1'b0;
         end else if (issue_go) begin
            bus_issue <= 1'b0;
            bus_finish <= 1'b1;
         end else if (bus_finish) begin
            bus_finish <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   // Read data mux; memory data arrive the cycle after issue
   always_comb begin
      rd_word = 32'h0000_0000;
      if (bus_mem) begin
         rd_word = mem_rdata;
      end else begin
         case (bus_addr)
            OFF_CTRL: rd_word = {29'h0, ctrl};
            OFF_VT_BASE: rd_word = {{VT_PAGE_BITS{1'b0}}, vector_table_base_reg};
            OFF_ERR_SUM: rd_word = {27'h0, error_summary_reg};
            OFF_CPU_OFF: rd_word = cpu_off;
            OFF_PLAT_OFF: rd_word = platform_info_offset;
            OFF_FRAME_SIZE: rd_word = frame_size;
            OFF_FRAME_BASE: rd_word = {26'h0, frame_base, 2'b00};
            OFF_LOC_LO: rd_word = frame_locator_register[31:0];
            OFF_LOC_HI: rd_word = frame_locator_register[63:32];
            OFF_VA_LO: rd_word = handler_va[31:0];
            OFF_VA_HI: rd_word = handler_va[63:32];
            OFF_PARAM_LO: rd_word = handler_param[31:0];
            OFF_PARAM_HI: rd_word = handler_param[63:32];
            OFF_STATUS: rd_word = {24'h0, last_class, 2'b00, vec_fault, console_halt};
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   // Read data register, loaded as the wait state ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_finish) begin
         hrdata <= bus_wr ? 32'h0000_0000 : rd_word;
      end
   end

   // Configuration registers written by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RST;
         vector_table_base_reg <= '0;
         cpu_off <= CPU_OFF_RST;
         platform_info_offset <= PLAT_OFF_RST;
         frame_size <= FRAME_SIZE_RST;
         frame_base <= '0;
      end else if (issue_go && bus_wr) begin
         case (bus_addr)
            OFF_CTRL: ctrl <= hwdata[2:0];
            OFF_VT_BASE: vector_table_base_reg <= hwdata[VT_PFN_W-1:0];
            OFF_CPU_OFF: cpu_off <= hwdata;
            OFF_PLAT_OFF: platform_info_offset <= hwdata;
            OFF_FRAME_SIZE: frame_size <= hwdata;
            OFF_FRAME_BASE: frame_base <= hwdata[LOG_AW+1:2];
            default: begin
            end
         endcase
      end
   end

   // Error summary: busy bits are write-one-to-clear, a hardware set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_summary_reg <= 5'h00;
      end else begin
         if (issue_go && bus_wr && bus_addr == OFF_ERR_SUM) begin
            error_summary_reg[2:0] <= (error_summary_reg[2:0] & ~hwdata[2:0]) | sum_set;
            error_summary_reg[4:3] <= hwdata[4:3];
         end else begin
            error_summary_reg[2:0] <= error_summary_reg[2:0] | sum_set;
         end
      end
   end

   // Halt and fault status; halt holds until reset since the console owns recovery
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         console_halt <= 1'b0;
         vec_fault <= 1'b0;
         last_class <= CL_FAULT;
      end else begin
         if (state == ST_IDLE && take_any && take_fatal && take_busy) begin
            console_halt <= 1'b1;
         end
         if ((state == ST_FETCH_VA) && !vt_req && !in_range) begin
            vec_fault <= 1'b1;
         end
         if (start_go) begin
            last_class <= classify(next_vec);
         end
      end
   end

   // Dispatch sequencer: frame header, table fetch, handler entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         cur_vec <= 16'h0000;
         cur_flags <= 32'h0000_0000;
         cur_corr <= 1'b0;
         cur_built <= 1'b0;
         cur_base <= '0;
         corr_live <= 1'b0;
         corr_flags <= 32'h0000_0000;
         corr_base <= '0;
         vt_req <= 1'b0;
         vt_addr <= 32'h0000_0000;
         handler_start <= 1'b0;
         handler_va <= 64'h0;
         handler_param <= 64'h0;
         frame_locator_register <= LOCATOR_NONE;
      end else begin
         handler_start <= 1'b0;
         if (error_summary_reg[2:1] == 2'b00) begin
            corr_live <= 1'b0;   // Area released by software
         end
         unique case (state)
            ST_IDLE: begin
               if (start_go) begin
                  cur_vec <= next_vec;
                  cur_corr <= !take_fatal;
                  cur_built <= ctrl[CTRL_BUILD_BIT];
                  cur_base <= frame_base;
                  cur_flags <= take_fatal ? {retry_ok, 31'h0} : {1'b1, 31'h0};
                  state <= ctrl[CTRL_BUILD_BIT] ? ST_HDR0 : ST_FETCH_VA;
               end else if (take_any && !take_fatal && take_busy && corr_live) begin
                  state <= ST_FIX;   // Frame kept, only its flag word changes
               end
            end
            ST_HDR0: state <= ST_HDR1;
            ST_HDR1: state <= ST_HDR2;
            ST_HDR2: state <= ST_HDR3;
            ST_HDR3: begin
               corr_live <= cur_corr;
               corr_flags <= cur_flags;
               corr_base <= cur_base;
               state <= ST_FETCH_VA;
            end
            ST_FIX: begin
               corr_flags[FLAG_SECOND_BIT] <= 1'b1;
               state <= ST_IDLE;
            end
            ST_FETCH_VA: begin
               if (!vt_req) begin
                  if (in_range) begin
                     vt_req <= 1'b1;
                     vt_addr <= entry_addr;
                  end else begin
                     state <= ST_IDLE;
                  end
               end else if (vt_ack) begin
                  handler_va <= vt_rdata;
                  vt_req <= 1'b0;
                  state <= ST_FETCH_PARAM;
               end
            end
            ST_FETCH_PARAM: begin
               if (!vt_req) begin
                  vt_req <= 1'b1;
                  vt_addr <= entry_addr + PARAM_STEP;
               end else if (vt_ack) begin
                  handler_param <= vt_rdata;
                  vt_req <= 1'b0;
                  state <= ST_ENTER;
               end
            end
            ST_ENTER: begin
               handler_start <= 1'b1;
               frame_locator_register <= cur_built ?
                  {58'h0, cur_base, 2'b00} : LOCATOR_NONE;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_size_word: assert property ((state == ST_HDR0) |-> mem_we && mem_addr == cur_base && mem_wdata == frame_size) else $error("size word not written");
   a_flags_low: assert property ((state == ST_HDR1) |-> mem_we && mem_wdata[29:0] == 30'h0 && (!cur_corr || mem_wdata[31])) else $error("flag word malformed");
   a_fatal_second: assert property ((state == ST_HDR1 && !cur_corr) |-> !mem_wdata[30]) else $error("second flag on fatal frame");
   a_header_offsets: assert property ((state == ST_HDR2) |-> mem_wdata == cpu_off ##1 (state == ST_HDR3 && mem_wdata == platform_info_offset)) else $error("offset words wrong");
   a_entry_fetch: assert property ((state == ST_FETCH_VA && vt_req) |-> vt_addr == vt_base_addr + {16'h0000, cur_vec}) else $error("vector fetch address wrong");
   // Error dispatch only ever uses the statically allocated part of the table
   a_static_vec: assert property ((state == ST_FETCH_VA) |-> cur_vec <= STATIC_LAST) else $error("dispatch vector outside static entries");
   a_param_fetch: assert property ((state == ST_FETCH_PARAM && vt_req) |-> vt_addr == entry_addr + 32'h8) else $error("parameter fetch address wrong");
   a_locator_val: assert property ($rose(handler_start) |-> frame_locator_register == (cur_built ? {58'h0, cur_base, 2'b00} : 64'hFFFF_FFFF_FFFF_FFFF)) else $error("locator mismatch");
   a_double_halt: assert property ((state == ST_IDLE && take_any && take_fatal && error_summary_reg[MCHK_BUSY_BIT]) |=> console_halt) else $error("double fatal did not halt");
   a_busy_first: assert property ((state == ST_IDLE && start_go && take_fatal) |=> error_summary_reg[MCHK_BUSY_BIT] && !handler_start) else $error("busy flag not set before entry");
   a_build_start: assert property ((state == ST_IDLE && start_go && ctrl[CTRL_BUILD_BIT]) |=> state == ST_HDR0 ##4 state == ST_FETCH_VA) else $error("frame not built before fetch");
endmodule : mcheck_dispatch

// [dv/mcheck_logout_and_vector_table_tb.sv]
/*
 Self-checking bench for the error dispatch block: frame header, locator,
 table fetch and double-error halt, seen through the bus and the table port.
 Assumes the block is the only slave on the bus and the bench answers table reads.
*/
`timescale 1ns/1ps

module mcheck_logout_and_vector_table_tb import mck_pkg::*; ;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, vt_req, vt_ack, retry_ok;
   logic handler_start, console_halt;
   logic [31:0] haddr, hwdata, hrdata, vt_addr, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] err; // Indexed by the event numbers of the package
   logic [63:0] vt_rdata, handler_va, handler_param, frame_locator_register;
   int err_total, cmp_count;

   mcheck_dispatch u_mcheck_dispatch (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .err_proc_fatal(err[0]), .err_sys_fatal(err[1]), .err_proc_corr(err[2]),
      .err_sys_corr(err[3]), .retry_ok(retry_ok), .vt_req(vt_req), .vt_addr(vt_addr),
      .vt_ack(vt_ack), .vt_rdata(vt_rdata), .handler_start(handler_start),
      .handler_va(handler_va), .handler_param(handler_param),
      .frame_locator_register(frame_locator_register), .console_halt(console_halt));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Table memory stand-in: data echoes the address, so a wrong fetch shows up
   always @(posedge hclk) begin
      vt_ack <= vt_req && !vt_ack;
      vt_rdata <= vt_req ? {32'h0000_0000, vt_addr} : ~vt_rdata;
   end

   // One single word transfer; waits as long as the slave stretches it
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {23'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   // One-cycle pulse on one error source
   task automatic pulse(input int i);
      @(posedge hclk);
      err[i] <= 1'b1;
      @(posedge hclk);
      err <= 4'h0;
   endtask : pulse

   // Bounded wait for the handler entry strobe
   task automatic wait_start;
      for (int i = 0; i < 80 && handler_start !== 1'b1; i++) @(posedge hclk);
      chk({63'h0, handler_start}, 64'h1);
   endtask : wait_start

   // Corrected error with frame build, table at page one, then a repeat error
   task automatic t_corr;
      bus(1'b1, OFF_VT_BASE, 32'h0000_0001);
      pulse(2);
      wait_start;
      chk(handler_va, 64'h2630);
      chk(handler_param, 64'h2638);
      chk(frame_locator_register, 64'h0);
      bus(1'b0, 9'h100, 32'h0);
      chk({32'h0, rd}, 64'h40);
      bus(1'b0, 9'h104, 32'h0);
      chk({32'h0, rd}, 64'h8000_0000);
      bus(1'b0, 9'h108, 32'h0);
      chk({32'h0, rd}, 64'h10);
      bus(1'b0, 9'h10C, 32'h0);
      chk({32'h0, rd}, 64'h40);
      pulse(2);
      repeat (4) @(posedge hclk);
      bus(1'b0, 9'h104, 32'h0);
      chk({32'h0, rd}, 64'hC000_0000);
      $display("test corr done");
   endtask : t_corr

   // Fatal error with a frame at word eight and retry refused, then busy flag clear
   task automatic t_fatal_frame;
      retry_ok <= 1'b0;
      bus(1'b1, OFF_FRAME_BASE, 32'h0000_0020);
      pulse(0);
      wait_start;
      retry_ok <= 1'b1;
      chk(handler_va, 64'h2670);
      chk(frame_locator_register, 64'h20);
      bus(1'b0, 9'h124, 32'h0);
      chk({32'h0, rd}, 64'h0);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({32'h0, rd}, 64'h80);
      bus(1'b0, OFF_ERR_SUM, 32'h0);
      chk({32'h0, rd}, 64'h5);
      bus(1'b1, OFF_ERR_SUM, 32'h0000_0001);
      bus(1'b0, OFF_ERR_SUM, 32'h0);
      chk({32'h0, rd}, 64'h4);
      $display("test fatal frame done");
   endtask : t_fatal_frame

   // Fatal error with build off, then a second fatal while still busy
   task automatic t_fatal;
      bus(1'b1, OFF_CTRL, 32'h0000_0000);
      pulse(1);
      wait_start;
      chk(frame_locator_register, LOCATOR_NONE);
      chk(handler_va, 64'h2660);
      pulse(0);
      repeat (3) @(posedge hclk);
      chk({63'h0, console_halt}, 64'h1);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({32'h0, rd}, 64'h81);
      $display("test fatal done");
   endtask : t_fatal

   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // Hang guard, well above the roughly 125 cycles the tests need
   initial begin
      repeat (5000) @(posedge hclk);
      err_total++;
      stop_test;
   end

   initial begin
      {hsel, hwrite, err, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      retry_ok = 1'b1;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(frame_locator_register, LOCATOR_NONE);
      t_corr;
      t_fatal_frame;
      t_fatal;
      stop_test;
   end
endmodule : mcheck_logout_and_vector_table_tb
